// ===== logic/serial_host_port_pkg.sv
package serial_host_port_pkg;

	// ----------------------------------------------------------------
	// command word layout and transfer limits
	// ----------------------------------------------------------------
	localparam int CMD_BITS = 32;
	localparam int CMD_WRITE_BIT = 31;
	localparam int CMD_INCR_BIT = 30;
	localparam int CMD_FUNC_LSB = 28;
	localparam int CMD_ADDR_LSB = 11;
	localparam int CMD_LEN_LSB = 0;
	localparam logic [11:0] MAX_XFER_BYTES = 12'h800;
	localparam logic [11:0] STD_FN_MAX_BYTES = 12'h020;
	localparam logic [11:0] BACKPLANE_MAX_BYTES = 12'h040;
	localparam logic [11:0] WLAN_MAX_BYTES = 12'h200;
	localparam logic [1:0] FN_STD = 2'h0;
	localparam logic [1:0] FN_BACKPLANE = 2'h1;
	localparam logic [1:0] FN_WLAN = 2'h2;
	localparam logic [1:0] FN_THIRD = 2'h3;

	// ----------------------------------------------------------------
	// status word bit positions
	// ----------------------------------------------------------------
	localparam int ST_NOT_AVAIL = 0;
	localparam int ST_UNDERFLOW = 1;
	localparam int ST_OVERFLOW = 2;
	localparam int ST_WLAN_IRQ = 3;
	localparam int ST_THIRD_IRQ = 4;
	localparam int ST_WLAN_RDY = 5;
	localparam int ST_THIRD_RDY = 6;
	localparam int ST_WLAN_PKT = 8;
	localparam int ST_WLAN_LEN_LSB = 9;
	localparam int ST_THIRD_PKT = 20;
	localparam int ST_THIRD_LEN_LSB = 21;

	// ----------------------------------------------------------------
	// straps, reset values, timing
	// ----------------------------------------------------------------
	localparam logic [2:0] SERIAL_STRAP = 3'h2;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [7:0] RESP_DELAY_RST = 8'h04;
	localparam int SCLK_MAX_MHZ = 48;
	localparam int CLK_MHZ = 250;
	localparam int SCLK_HALF_CYCLES = CLK_MHZ / (2 * SCLK_MAX_MHZ);

	typedef struct packed {
		logic write;
		logic incr;
		logic [1:0] func;
		logic [16:0] addr;
		logic [10:0] len;
	} xfer_s;

	typedef struct packed {
		logic word32;
		logic big_end;
		logic high_speed;
		logic status_en;
		logic delay_all;
		logic irq_high;
		logic [7:0] resp_delay;
	} cfg_s;

	localparam cfg_s CFG_RST = '{word32: 1'b0, big_end: 1'b0, high_speed: 1'b1,
		status_en: 1'b1, delay_all: 1'b0, irq_high: 1'b1, resp_delay: RESP_DELAY_RST};

	typedef struct packed {
		logic wlan_irq;
		logic third_irq;
		logic wlan_rdy;
		logic third_rdy;
		logic wlan_pkt;
		logic [10:0] wlan_len;
		logic third_pkt;
		logic [10:0] third_len;
	} dev_status_s;

	// wire order is msb first; little endian swaps bytes per frame word
	function automatic logic [31:0] order_bytes(input logic [31:0] w, input logic w32,
		input logic be);
		if (be) begin
			return w;
		end else if (w32) begin
			return {w[7:0], w[15:8], w[23:16], w[31:24]};
		end
		return {w[23:16], w[31:24], w[7:0], w[15:8]};
	endfunction

endpackage

// ===== logic/pin_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser with edge detection behind the second flop
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// meta_q feeds sync_q only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
			prev_q <= RST_VAL;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule // pin_sync

// ===== logic/wlan_serial_host_port.sv
`timescale 1ns/100ps
module wlan_serial_host_port
	import serial_host_port_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [2:0] strap_host_ifc,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic di,
	output logic do_o,
	output logic do_oe,
	output logic irq_o,
	output logic irq_oe,
	output logic serial_mode,
	input wire cfg_s cfg,
	input wire logic irq_req,
	input wire dev_status_s dev_status,
	output xfer_s cmd,
	output logic cmd_valid,
	output logic [16:0] xfer_addr,
	output logic [31:0] wr_data,
	output logic [16:0] wr_addr,
	output logic wr_valid,
	input wire logic wr_ready,
	input wire logic [31:0] rd_data,
	input wire logic rd_valid,
	output logic rd_pop,
	output logic [2:0] xfer_flags
);
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_CMD = 7'h02,
		ST_WDATA = 7'h04,
		ST_DELAY = 7'h08,
		ST_RDATA = 7'h10,
		ST_STATUS = 7'h20,
		ST_HOLD = 7'h40
	} port_state_e;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] link_lvl;
	logic [2:0] link_rise;
	logic [2:0] link_fall;
	logic [2:0] strap_lvl;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_lvl;
	logic cs_rise;
	logic cs_fall;
	logic di_lvl;

	// oversampling at 250 MHz gives at least two samples per 48 MHz half period
	pin_sync #(.W(3), .RST_VAL(3'h2)) u_link_sync (
		.clk(clk),
		.arst_n(arst_n),
		.pin({di, cs_n, sclk}),
		.level(link_lvl),
		.rise(link_rise),
		.fall(link_fall)
	);

	pin_sync #(.W(3), .RST_VAL(3'h0)) u_strap_sync (
		.clk(clk),
		.arst_n(arst_n),
		.pin(strap_host_ifc),
		.level(strap_lvl),
		.rise(),
		.fall()
	);

	assign sclk_rise = link_rise[0];
	assign sclk_fall = link_fall[0];
	assign cs_lvl = link_lvl[1];
	assign cs_rise = link_rise[1];
	assign cs_fall = link_fall[1];
	assign di_lvl = link_lvl[2];

	// ----------------------------------------------------------------
	// strap capture and configuration
	// ----------------------------------------------------------------
	logic [1:0] strap_cnt_q;
	logic serial_mode_q;
	cfg_s cfg_q;

	// straps are taken once, after the synchroniser has filled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_cnt_q <= 2'h0;
			serial_mode_q <= 1'b0;
		end else if (strap_cnt_q < STRAP_SETTLE) begin
			strap_cnt_q <= strap_cnt_q + 2'h1; // parks at three, so straps are taken once
		end else if (strap_cnt_q == STRAP_SETTLE) begin
			strap_cnt_q <= STRAP_SETTLE + 2'h1;
			serial_mode_q <= (strap_lvl == SERIAL_STRAP);
		end
	end

	// configuration only moves between frames, also while a read is parked, never mid-frame
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= CFG_RST;
		end else if (cs_lvl) begin
			cfg_q <= cfg;
		end
	end

	// ----------------------------------------------------------------
	// bit timing
	// ----------------------------------------------------------------
	logic rx_edge;
	logic tx_edge;
	logic [4:0] bit_cnt_q;
	logic word_end;
	logic [31:0] rx_q;
	logic [31:0] rx_word;
	xfer_s rx_cmd;

	assign rx_edge = serial_mode_q & ~cs_lvl & sclk_rise;
	// high speed launches on the capture edge, normal mode on the opposite
	assign tx_edge = serial_mode_q & ~cs_lvl &
		(cfg_q.high_speed ? sclk_rise : sclk_fall);
	assign word_end = rx_edge & (bit_cnt_q == 5'h1F);
	assign rx_word = order_bytes({rx_q[30:0], di_lvl}, cfg_q.word32, cfg_q.big_end);
	assign rx_cmd = xfer_s'(rx_word);

	function automatic logic [9:0] words_of(input xfer_s c);
		logic [11:0] len;
		logic [11:0] cap;
		logic [11:0] sum;
		len = (c.len == 11'h000) ? MAX_XFER_BYTES : {1'b0, c.len};
		unique case (c.func)
			FN_STD: cap = STD_FN_MAX_BYTES;
			FN_BACKPLANE: cap = BACKPLANE_MAX_BYTES;
			FN_WLAN: cap = WLAN_MAX_BYTES;
			FN_THIRD: cap = MAX_XFER_BYTES;
		endcase
		if (len > cap) begin
			len = cap;
		end
		sum = len + 12'h003;
		return sum[11:2];
	endfunction

	function automatic logic [10:0] delay_of(input xfer_s c, input cfg_s g);
		if (c.func == FN_BACKPLANE || g.delay_all) begin
			return {g.resp_delay, 3'h0};
		end
		return 11'h000;
	endfunction

	// ----------------------------------------------------------------
	// transaction sequencer
	// ----------------------------------------------------------------
	port_state_e state_q;
	port_state_e state_d;
	logic fresh_q;
	logic [9:0] words_left_q;
	logic [10:0] delay_left_q;
	logic cmd_done;
	logic load_rd;
	logic load_st;
	logic wr_fire;
	logic new_cmd;

	assign new_cmd = cs_fall & (state_q != ST_HOLD);

	always_comb begin
		state_d = state_q;
		cmd_done = 1'b0;
		load_rd = 1'b0;
		load_st = 1'b0;
		wr_fire = 1'b0;
		if (!serial_mode_q) begin
			state_d = ST_IDLE;
		end else if (cs_rise) begin
			// a read parked right after its command resumes at the next select
			state_d = ((state_q == ST_DELAY || state_q == ST_RDATA) && fresh_q) ?
				ST_HOLD : ST_IDLE;
		end else if (cs_fall) begin
			if (state_q == ST_HOLD) begin
				state_d = (delay_left_q != 11'h000) ? ST_DELAY : ST_RDATA;
			end else begin
				state_d = ST_CMD;
			end
		end else if (rx_edge) begin
			unique case (state_q)
				ST_CMD: begin
					if (word_end) begin
						cmd_done = 1'b1;
						if (rx_cmd.write) begin
							state_d = ST_WDATA;
						end else if (delay_of(rx_cmd, cfg_q) != 11'h000) begin
							state_d = ST_DELAY;
						end else begin
							state_d = ST_RDATA;
							load_rd = 1'b1;
						end
					end
				end
				ST_WDATA: begin
					if (word_end) begin
						wr_fire = 1'b1;
						if (words_left_q == 10'h001) begin
							load_st = cfg_q.status_en;
							state_d = cfg_q.status_en ? ST_STATUS : ST_IDLE;
						end
					end
				end
				ST_DELAY: begin
					if (delay_left_q == 11'h001) begin
						state_d = ST_RDATA;
						load_rd = 1'b1;
					end
				end
				ST_RDATA: begin
					if (word_end) begin
						if (words_left_q == 10'h001) begin
							load_st = cfg_q.status_en;
							state_d = cfg_q.status_en ? ST_STATUS : ST_IDLE;
						end else begin
							load_rd = 1'b1;
						end
					end
				end
				ST_STATUS: begin
					if (word_end) begin
						state_d = ST_IDLE;
					end
				end
				ST_IDLE, ST_HOLD: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// bit, word and delay counters
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt_q <= 5'h00;
			words_left_q <= 10'h000;
			delay_left_q <= 11'h000;
			fresh_q <= 1'b0;
		end else begin
			if (cs_fall || (load_rd && state_q == ST_DELAY)) begin
				bit_cnt_q <= 5'h00;
			end else if (rx_edge) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
			if (cmd_done) begin
				words_left_q <= words_of(rx_cmd);
				delay_left_q <= delay_of(rx_cmd, cfg_q);
			end else if (word_end && (state_q == ST_WDATA || state_q == ST_RDATA)) begin
				words_left_q <= words_left_q - 10'h001;
			end else if (rx_edge && state_q == ST_DELAY) begin
				delay_left_q <= delay_left_q - 11'h001;
			end
			if (cmd_done) begin
				fresh_q <= 1'b1;
			end else if (rx_edge) begin
				fresh_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_q <= 32'h0000_0000;
		end else if (rx_edge) begin
			rx_q <= {rx_q[30:0], di_lvl};
		end
	end

	// ----------------------------------------------------------------
	// transaction flags and status word
	// ----------------------------------------------------------------
	logic [2:0] flags_q;
	logic [2:0] flags_d;
	logic [2:0] flags_set;
	logic [31:0] status_word;
	logic [1:0] cur_func;

	// a read without delay loads its first word before cmd has been updated
	assign cur_func = cmd_done ? rx_cmd.func : cmd.func;

	always_comb begin
		flags_set = 3'h0;
		flags_set[ST_NOT_AVAIL] = load_rd & ~rd_valid;
		flags_set[ST_UNDERFLOW] = load_rd & ~rd_valid & cur_func[1];
		flags_set[ST_OVERFLOW] = wr_fire & ~wr_ready & (cmd.func != FN_STD);
		// a flag raised in the clearing cycle survives
		flags_d = (new_cmd ? 3'h0 : flags_q) | flags_set;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= 3'h0;
		end else begin
			flags_q <= flags_d;
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_OVERFLOW:ST_NOT_AVAIL] = flags_d;
		status_word[ST_WLAN_IRQ] = dev_status.wlan_irq;
		status_word[ST_THIRD_IRQ] = dev_status.third_irq;
		status_word[ST_WLAN_RDY] = dev_status.wlan_rdy;
		status_word[ST_THIRD_RDY] = dev_status.third_rdy;
		status_word[ST_WLAN_PKT] = dev_status.wlan_pkt;
		status_word[ST_WLAN_LEN_LSB +: 11] = dev_status.wlan_len;
		status_word[ST_THIRD_PKT] = dev_status.third_pkt;
		status_word[ST_THIRD_LEN_LSB +: 11] = dev_status.third_len;
	end

	// ----------------------------------------------------------------
	// transmit path
	// ----------------------------------------------------------------
	logic [31:0] tx_q;
	logic [31:0] tx_d;
	logic [31:0] rd_word;

	assign rd_word = rd_valid ? rd_data : 32'h0000_0000;

	always_comb begin
		tx_d = tx_q;
		if (new_cmd) begin
			tx_d = 32'h0000_0000;
		end else if (load_rd) begin
			tx_d = order_bytes(rd_word, cfg_q.word32, cfg_q.big_end);
		end else if (load_st) begin
			tx_d = order_bytes(status_word, cfg_q.word32, cfg_q.big_end);
		end else if (rx_edge) begin
			tx_d = {tx_q[30:0], 1'b0};
		end
	end

	// next bit goes out on the launch edge, ahead of the host's next rising edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_q <= 32'h0000_0000;
			do_o <= 1'b0;
			do_oe <= 1'b0;
		end else begin
			tx_q <= tx_d;
			do_oe <= serial_mode_q & ~cs_lvl;
			if (!serial_mode_q || cs_lvl) begin
				do_o <= 1'b0;
			end else if (cs_fall || tx_edge) begin
				do_o <= tx_d[31];
			end
		end
	end

	// ----------------------------------------------------------------
	// user side strobes
	// ----------------------------------------------------------------
	logic [16:0] addr_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd <= '0;
			cmd_valid <= 1'b0;
			addr_q <= 17'h00000;
			wr_addr <= 17'h00000;
			wr_data <= 32'h0000_0000;
			wr_valid <= 1'b0;
			rd_pop <= 1'b0;
		end else begin
			cmd_valid <= cmd_done;
			wr_valid <= wr_fire & wr_ready; // dropped words show as overflow unless cmd.func is FN_STD
			rd_pop <= load_rd & rd_valid;
			if (cmd_done) begin
				cmd <= rx_cmd;
				addr_q <= (load_rd && rx_cmd.incr) ? rx_cmd.addr + 17'h00004 : rx_cmd.addr;
			end else if ((wr_fire || load_rd) && cmd.incr) begin
				addr_q <= addr_q + 17'h00004;
			end
			if (wr_fire) begin
				wr_data <= rx_word;
				wr_addr <= addr_q;
			end
		end
	end

	assign xfer_addr = addr_q;
	assign xfer_flags = flags_q;
	assign serial_mode = serial_mode_q;

	// interrupt pin drives only in serial mode, polarity as configured
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_o <= 1'b0;
			irq_oe <= 1'b0;
		end else begin
			irq_oe <= serial_mode_q;
			irq_o <= serial_mode_q & (cfg_q.irq_high ? irq_req : ~irq_req);
		end
	end
endmodule // wlan_serial_host_port

// ===== bench/shp_assertions.sv
`timescale 1ns/100ps
// watches the pins and the user side of the serial host port
module shp_checker
	import serial_host_port_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic do_o,
	input wire logic do_oe,
	input wire logic irq_o,
	input wire logic irq_oe,
	input wire logic serial_mode,
	input wire cfg_s cfg,
	input wire logic irq_req,
	input wire xfer_s cmd,
	input wire logic cmd_valid,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic rd_pop
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	// margin of six cycles covers the chip select synchroniser
	oe_idle_a: assert property (cs_n [*6] |-> !do_oe && !do_o)
		else $error("data out driven with chip select high");
	mode_oe_a: assert property (!serial_mode |-> !do_oe && !irq_oe)
		else $error("pins driven outside serial mode");
	// six cycles let a new cfg reach the latched copy through the cs synchroniser
	irq_level_a: assert property ((serial_mode && cs_n && $stable(irq_req) && $stable(cfg)) [*6]
		|-> irq_o == (irq_req ^ !cfg.irq_high))
		else $error("interrupt pin level wrong");
	// launch lands while the launching sclk level still stands
	shift_edge_a: assert property ($changed(do_o) && do_oe && $past(do_oe, 2)
		|-> sclk == cfg.high_speed)
		else $error("data out moved on the wrong sclk edge");

	// ----------------------------------------------------------------
	// user side
	// ----------------------------------------------------------------
	cmd_frame_a: assert property (cmd_valid |-> !cs_n && !$past(cmd_valid))
		else $error("command pulse outside a frame");
	wr_pulse_a: assert property (wr_valid |-> $past(wr_ready) ##1 !wr_valid)
		else $error("write word passed while refused");
	wr_dir_a: assert property (wr_valid |-> cmd.write)
		else $error("write word under a read command");
	rd_dir_a: assert property (rd_pop |-> !cmd.write ##1 !rd_pop)
		else $error("read pop under a write command");
endmodule // shp_checker

bind wlan_serial_host_port shp_checker chk (.clk, .arst_n, .sclk, .cs_n, .do_o, .do_oe,
	.irq_o, .irq_oe, .serial_mode, .cfg, .irq_req, .cmd, .cmd_valid, .wr_valid, .wr_ready,
	.rd_pop);

// ===== bench/spi_host_model.sv
`timescale 1ns/100ps
// host serial master: sclk stands low between frames unless stray clocks are asked for
module spi_host_model #(
	parameter realtime HALF = 24.0
) (
	output logic sclk,
	output logic cs_n,
	output logic di,
	input wire logic do_o
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		di = 1'b0;
	end

	// ----------------------------------------------------------------
	// frame control
	// ----------------------------------------------------------------
	// odd offset keeps sclk unrelated in phase to the system clock
	task automatic open_frame();
		#1.3;
		cs_n = 1'b0;
	endtask
	task automatic close_frame();
		#(HALF);
		cs_n = 1'b1;
		di = ~di; // a stale bit must not look valid
		#(HALF * 4);
	endtask
	// msb first; di moves while sclk low, do_o taken at each rise
	task automatic shift(input logic [31:0] tx, output logic [31:0] rx);
		for (int i = 31; i >= 0; i--) begin
			di = tx[i];
			#(HALF);
			sclk = 1'b1;
			rx[i] = do_o;
			#(HALF);
			sclk = 1'b0;
		end
	endtask
	// clocks with chip select high, only when the bench asks for them
	task automatic stray(input int n);
		repeat (n) begin
			#(HALF) sclk = 1'b1;
			#(HALF) sclk = 1'b0;
		end
	endtask
endmodule // spi_host_model

// ===== bench/tb_wlan_serial_host_port.sv
`timescale 1ns/100ps
module tb_wlan_serial_host_port;
	import serial_host_port_pkg::*;

	localparam dev_status_s DS = '{wlan_irq: 1'b1, third_irq: 1'b0, wlan_rdy: 1'b1,
		third_rdy: 1'b0, wlan_pkt: 1'b1, wlan_len: 11'h5A3, third_pkt: 1'b0, third_len: 11'h2C6};
	localparam logic [31:0] RD_WORD = 32'hA5C3_1E77;
	logic clk, arst_n, sclk, cs_n, di, do_o, do_oe, irq_o, irq_oe, serial_mode;
	logic irq_req, cmd_valid, wr_valid, wr_ready, rd_valid, rd_pop;
	logic [2:0] strap_host_ifc, xfer_flags;
	logic [16:0] xfer_addr, wr_addr;
	logic [31:0] wr_data, rd_data, rx;
	cfg_s cfg;
	dev_status_s dev_status;
	xfer_s cmd;
	int num_errors, checks_done, ncmd;
	logic [31:0] wq[$];
	logic [16:0] aq[$];

	spi_host_model host (.sclk, .cs_n, .di, .do_o);
	wlan_serial_host_port dut (.clk, .arst_n, .strap_host_ifc, .sclk, .cs_n, .di, .do_o, .do_oe,
		.irq_o, .irq_oe, .serial_mode, .cfg, .irq_req, .dev_status, .cmd, .cmd_valid, .xfer_addr,
		.wr_data, .wr_addr, .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_pop, .xfer_flags);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// user-side write words and commands, taken where they have settled
	always @(negedge clk) begin
		if (wr_valid) begin
			wq.push_back(wr_data);
			aq.push_back(wr_addr);
		end
		if (cmd_valid)
			ncmd++;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (num_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// wire view: as sent in big endian, else bytes swapped per frame word
	function automatic logic [31:0] wire_of(input logic [31:0] w);
		if (cfg.big_end)
			return w;
		if (cfg.word32)
			return {w[7:0], w[15:8], w[23:16], w[31:24]};
		return {w[23:16], w[31:24], w[7:0], w[15:8]};
	endfunction
	function automatic logic [31:0] st_exp(input logic [2:0] f);
		return {DS.third_len, DS.third_pkt, DS.wlan_len, DS.wlan_pkt, 1'b0, DS.third_rdy,
			DS.wlan_rdy, DS.third_irq, DS.wlan_irq, f};
	endfunction
	// config moves only with chip select high, so let it settle
	task automatic set_cfg(input logic w32, input logic be, input logic hs, input logic se);
		@(negedge clk);
		cfg = '{word32: w32, big_end: be, high_speed: hs, status_en: se, delay_all: 1'b0,
			irq_high: 1'b1, resp_delay: RESP_DELAY_RST};
		repeat (6) @(negedge clk);
	endtask
	// one frame, two when parked: command, delay word for delayed reads, data, status when enabled
	task automatic xfer(input logic wr, input logic [1:0] fn, input logic [16:0] addr,
		input int nw, input logic park, output logic [31:0] data, output logic [31:0] st);
		logic [31:0] c;
		c = {wr, 1'b1, fn, addr, 11'(nw * 4)};
		host.open_frame();
		host.shift(wire_of(c), rx);
		if (park) begin
			host.close_frame();
			repeat (40) @(negedge clk);
			host.open_frame();
		end
		if (!wr && (fn == FN_BACKPLANE || cfg.delay_all)) begin
			host.shift(32'h0, rx);
			cmp_word(rx, 32'h0);
		end
		for (int i = 0; i < nw; i++) begin
			host.shift(wire_of({15'h4A21, addr} + i), rx);
			data = wire_of(rx);
		end
		if (cfg.status_en) begin
			host.shift(32'h0, rx);
			st = wire_of(rx);
		end
		host.close_frame();
		repeat (8) @(negedge clk);
	endtask
	task automatic take_writes(input logic [16:0] a, input int n);
		cmp_word(wq.size(), n);
		for (int i = 0; i < n; i++) begin
			cmp_word(wq.pop_front(), {15'h4A21, a} + i);
			cmp_word(aq.pop_front(), a + 17'(4 * i));
		end
		wq.delete();
		aq.delete();
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d, st;
		arst_n = 1'b0;
		strap_host_ifc = SERIAL_STRAP;
		cfg = CFG_RST;
		irq_req = 1'b0;
		dev_status = DS;
		wr_ready = 1'b1;
		rd_data = RD_WORD;
		rd_valid = 1'b1;
		num_errors = 0;
		checks_done = 0;
		ncmd = 0;
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		repeat (10) @(negedge clk);
		cmp_word(32'(serial_mode), 32'h1);
		cmp_word(32'(irq_oe), 32'h1);
		irq_req = 1'b1;
		repeat (6) @(negedge clk);
		cmp_word(32'(irq_o), 32'h1);
		cfg.irq_high = 1'b0;
		repeat (6) @(negedge clk);
		cmp_word(32'(irq_o), 32'h0);
		cfg.irq_high = 1'b1;
		irq_req = 1'b0;
		host.stray(40);
		repeat (8) @(negedge clk);
		cmp_word(ncmd, 32'h0);
		cmp_word(32'(do_oe), 32'h0);
		// 16-bit and 32-bit little endian framing and 32-bit big endian, host to device and back
		for (int m = 0; m < 3; m++) begin
			set_cfg(m > 0, m == 2, 1'b1, 1'b1);
			xfer(1'b1, FN_WLAN, 17'h00040, 1, 1'b0, d, st);
			take_writes(17'h00040, 1);
			cmp_word(cmd, {1'b1, 1'b1, FN_WLAN, 17'h00040, 11'h004});
			cmp_word(st, st_exp(3'h0));
		end
		cmp_word(ncmd, 32'h3);
		set_cfg(1'b1, 1'b1, 1'b1, 1'b1);
		xfer(1'b1, FN_BACKPLANE, 17'h00100, 2, 1'b0, d, st);
		take_writes(17'h00100, 2);
		cmp_word(32'(xfer_addr), 32'h108);
		wr_ready = 1'b0;
		xfer(1'b1, FN_WLAN, 17'h00200, 1, 1'b0, d, st);
		wr_ready = 1'b1;
		take_writes(17'h00200, 0);
		cmp_word(st, st_exp(3'h4));
		cmp_word(32'(xfer_flags), 32'h4);
		// backplane reads on either shifting edge
		for (int hs = 1; hs >= 0; hs--) begin
			set_cfg(1'b1, 1'b1, 1'(hs), 1'b1);
			xfer(1'b0, FN_BACKPLANE, 17'h00300, 1, 1'b0, d, st);
			cmp_word(d, RD_WORD);
			cmp_word(st, st_exp(3'h0));
			cmp_word(32'(xfer_addr), 32'h304);
		end
		// parked read: its command in one frame, its data in the next
		set_cfg(1'b1, 1'b1, 1'b1, 1'b1);
		xfer(1'b1, FN_BACKPLANE, 17'h00400, 1, 1'b0, d, st);
		take_writes(17'h00400, 1);
		xfer(1'b0, FN_BACKPLANE, 17'h00400, 1, 1'b1, d, st);
		cmp_word(d, RD_WORD);
		rd_valid = 1'b0;
		xfer(1'b0, FN_WLAN, 17'h00500, 1, 1'b0, d, st);
		rd_valid = 1'b1;
		cmp_word(d, 32'h0);
		cmp_word(st, st_exp(3'h3));
		cmp_word(32'(xfer_flags), 32'h3);
		cmp_word(32'(xfer_addr), 32'h504);
		// delay word in front of an FN_STD read once it is enabled for all
		cfg.delay_all = 1'b1;
		repeat (6) @(negedge clk);
		xfer(1'b0, FN_STD, 17'h00700, 1, 1'b0, d, st);
		cfg.delay_all = 1'b0;
		cmp_word(d, RD_WORD);
		cmp_word(st, st_exp(3'h0));
		set_cfg(1'b1, 1'b1, 1'b1, 1'b0);
		xfer(1'b1, FN_THIRD, 17'h00600, 1, 1'b0, d, st);
		take_writes(17'h00600, 1);
		test_done();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		test_done();
	end
endmodule // tb_wlan_serial_host_port
